// file: design/isk_pkg.sv
/*
  Shared constants and types for the increment-and-skip execute block.
  Assumes a 16-bit instruction word and a 12-bit data address space.
*/
package isk_pkg;

  localparam int          INSTR_W        = 16;
  localparam int          DADDR_W        = 12;
  localparam int          DATA_W         = 8;
  localparam int          BANK_W         = 4;
  localparam int          OPC_MSB        = 15;
  localparam int          OPC_LSB        = 10;
  localparam int          DEST_BIT       = 9;
  localparam int          ACC_BIT        = 8;
  localparam int          FADDR_MSB      = 7;
  localparam int          FADDR_LSB      = 0;
  localparam logic [5:0]  OPC_INC_SKIP_Z = 6'h0f;
  localparam logic [5:0]  OPC_INC_SKIP_NZ = 6'h12;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
  localparam logic [7:0]  INDEX_LIMIT    = 8'h5f;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
  localparam logic [1:0]  SQUASH_NONE    = 2'h0;
  localparam logic [1:0]  SQUASH_ONE     = 2'h1;
  localparam logic [1:0]  SQUASH_TWO     = 2'h2;

  typedef enum logic [1:0] {
    ISK_RUN   = 2'b00,
    ISK_SKIP1 = 2'b01,
    ISK_SKIP2 = 2'b11
  } isk_state_type;

endpackage

// file: design/isk_addr_if.sv
/*
  Carrier between the execute block and its file address generator.
  Assumes both ends share the core clock; the content is combinational.
*/
`timescale 1ns/1ps
interface isk_addr_if;
  import isk_pkg::*;
  logic [7:0]         file_addr;
  logic               access_bit;
  logic [BANK_W-1:0]  bank_select_register;
  logic               ext_set_enable;
  logic [DADDR_W-1:0] frame_pointer;
  logic [DADDR_W-1:0] full_addr;
  logic               indexed;

  modport exec (output file_addr, access_bit, bank_select_register, ext_set_enable, frame_pointer,
                input full_addr, indexed);
  modport gen  (input file_addr, access_bit, bank_select_register, ext_set_enable, frame_pointer,
                output full_addr, indexed);
endinterface

// file: design/isk_addr_gen.sv
/*
  File address generator: access bank, selected bank or indexed offset.
  Assumes the frame pointer already holds a full data address.
*/
`timescale 1ns/1ps
module isk_addr_gen
  import isk_pkg::*;
(
  // Address request and answer
  isk_addr_if.gen a
);

  logic index_mode;

  always_comb begin
    index_mode = !a.access_bit && a.ext_set_enable && (a.file_addr <= INDEX_LIMIT);
  end

  always_comb begin
    if (index_mode) begin
      a.full_addr = a.frame_pointer + {4'h0, a.file_addr};
    end else if (a.access_bit) begin
      a.full_addr = {a.bank_select_register, a.file_addr};
    end else if (a.file_addr < ACCESS_SPLIT) begin
      a.full_addr = {ACCESS_LO_BANK, a.file_addr};
    end else begin
      a.full_addr = {ACCESS_HI_BANK, a.file_addr};
    end
    a.indexed = index_mode;
  end

endmodule

// file: design/isk_exec.sv
/*
  Execute block for the two increment-and-skip instructions of an 8-bit core.

  What it does
    Every cycle the core offers one instruction word with a valid flag. When
    the word carries one of the two increment-and-skip opcodes and no skip is
    pending, the block forms the file address, reads the file register through
    a combinational read port, adds one and, one edge later, pulses either the
    file write or the accumulator write together with the executed flag.
    Skip on zero fires when the sum wraps to zero; skip on nonzero fires for
    any other sum. A fired skip raises squash for the next valid word, and for
    one more valid word when that squashed word is flagged as the first half
    of a two-word instruction.

  Addressing
    The bank bit picks the selected bank or the access bank. With the
    extended set on and the bank bit low, file addresses up to the index
    limit are taken as an offset from the frame pointer instead; the sum
    wraps within the data address space.

  Ports
    clk, resetn, ce        core clock, asynchronous active-low reset, enable
    instr_*                instruction word, valid flag, two-word flag
    bank_select_register,
    ext_set_enable,
    frame_pointer          addressing context from the core
    file_rd_*              combinational file read port
    file_wr_*, accum_wr_*  registered destination writes
    squash, executed       program flow towards the fetch stage
    status_wr_en           always low

  Timing
    Write enables and executed are one-cycle pulses; write data and address
    hold until the next executed instruction with the same destination.
    Squash comes straight from the
    state register, so the core can discard the word it presents in the same
    cycle. Cycles without a valid word do not advance the squash count.
    Example: a skip-on-zero word reading 8'hff writes 8'h00 at the next edge
    and raises squash for the word that follows; a word reading 8'h10 with
    the other opcode writes 8'h11 and squashes likewise.

  Reset
    Asynchronous and active low. All enables, data and the squash state
    clear; the first word may be offered in the cycle after release.

  Hazards and limits
    A squashed word is never decoded, even when it is one of ours. Status
    flags are never written; the status write enable is tied low so that a
    merge with other execute units cannot mistake this block for a writer.
    Clock enable low freezes all state, pulses included.

  Assumptions
    The core presents one instruction word per cycle with a valid flag,
    answers a file read combinationally in the same cycle, and flags when the
    presented word is the first word of a two-word instruction.
*/
`timescale 1ns/1ps
module isk_exec
  import isk_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               ce,
  // Instruction stream
  input  wire logic [INSTR_W-1:0] instr_word,
  input  wire logic               instr_valid,
  input  wire logic               instr_two_word,
  // Addressing context
  input  wire logic [BANK_W-1:0]  bank_select_register,
  input  wire logic               ext_set_enable,
  input  wire logic [DADDR_W-1:0] frame_pointer,
  // File register read
  output logic      [DADDR_W-1:0] file_rd_addr,
  input  wire logic [DATA_W-1:0]  file_rd_data,
  // Destination writes
  output logic                    file_wr_en,
  output logic      [DADDR_W-1:0] file_wr_addr,
  output logic      [DATA_W-1:0]  file_wr_data,
  output logic                    accum_wr_en,
  output logic      [DATA_W-1:0]  accum_wr_data,
  // Program flow
  output logic                    squash,
  output logic                    executed,
  output logic                    status_wr_en
);

  typedef struct packed {
    isk_state_type      state;
    logic               file_wr_en;
    logic [DADDR_W-1:0] file_wr_addr;
    logic [DATA_W-1:0]  file_wr_data;
    logic               accum_wr_en;
    logic [DATA_W-1:0]  accum_wr_data;
    logic               executed;
  } isk_regs_type;

  isk_regs_type r;
  isk_regs_type next_r;

  isk_addr_if addr_bus ();

  logic [5:0]        opcode;
  logic              is_skip_z;
  logic              is_skip_nz;
  logic              active;
  logic [DATA_W-1:0] result;
  logic              dest_file;
  logic              result_zero;
  logic              skip_z_hit;
  logic              skip_nz_hit;
  logic              take_skip;

  isk_addr_gen u_addr_gen (
    .a (addr_bus.gen)
  );

  // Split the instruction word into its fields
  always_comb begin
    opcode     = instr_word[OPC_MSB:OPC_LSB];
    is_skip_z  = (opcode == OPC_INC_SKIP_Z);
    is_skip_nz = (opcode == OPC_INC_SKIP_NZ);
    active     = instr_valid && (r.state == ISK_RUN) && (is_skip_z || is_skip_nz);
    addr_bus.file_addr            = instr_word[FADDR_MSB:FADDR_LSB];
    addr_bus.access_bit           = instr_word[ACC_BIT];
    addr_bus.bank_select_register = bank_select_register;
    addr_bus.ext_set_enable       = ext_set_enable;
    addr_bus.frame_pointer        = frame_pointer;
    file_rd_addr = addr_bus.full_addr;
    result       = file_rd_data + 8'h01;
    dest_file    = instr_word[DEST_BIT];

    // Skip decision from the wrapped sum
    result_zero  = (result == 8'h00);
    skip_z_hit   = is_skip_z && result_zero;
    skip_nz_hit  = is_skip_nz && !result_zero;
    take_skip    = active && (skip_z_hit || skip_nz_hit);
  end

  always_comb begin
    next_r = r;
    next_r.file_wr_en  = 1'b0;
    next_r.accum_wr_en = 1'b0;
    next_r.executed    = active;
    if (active) begin
      if (dest_file) begin
        next_r.file_wr_en   = 1'b1;
        next_r.file_wr_addr = addr_bus.full_addr;
        next_r.file_wr_data = result;
      end else begin
        next_r.accum_wr_en   = 1'b1;
        next_r.accum_wr_data = result;
      end
    end
    // The word after a skip is discarded; a two-word one costs one more valid word
    case (r.state)
      ISK_RUN: begin
        if (take_skip) begin
          next_r.state = ISK_SKIP1;
        end else begin
          next_r.state = ISK_RUN;
        end
      end
      ISK_SKIP1: begin
        if (instr_valid) begin
          next_r.state = instr_two_word ? ISK_SKIP2 : ISK_RUN;
        end else begin
          next_r.state = ISK_SKIP1;
        end
      end
      ISK_SKIP2: begin
        if (instr_valid) begin
          next_r.state = ISK_RUN;
        end else begin
          next_r.state = ISK_SKIP2;
        end
      end
      default: begin
        next_r.state = ISK_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  always_comb begin
    file_wr_en    = r.file_wr_en;
    file_wr_addr  = r.file_wr_addr;
    file_wr_data  = r.file_wr_data;
    accum_wr_en   = r.accum_wr_en;
    accum_wr_data = r.accum_wr_data;
    executed      = r.executed;
    squash        = (r.state != ISK_RUN);
    status_wr_en  = 1'b0;
  end

endmodule

// file: test/isk_monitor.sv
/* Checker for isk_exec, bound to its ports.
   Assumes one clock domain. */
`timescale 1ns/1ps
module isk_monitor
  import isk_pkg::*;
(
  // Control
  input wire logic clk, resetn, ce, instr_valid, instr_two_word, squash,
  // Data
  input wire logic [INSTR_W-1:0] instr_word,
  input wire logic [DATA_W-1:0] file_rd_data, file_wr_data, accum_wr_data,
  // Results
  input wire logic file_wr_en, accum_wr_en, executed, status_wr_en
);
  logic z, nz, tk;
  assign z = instr_word[OPC_MSB:OPC_LSB] == OPC_INC_SKIP_Z;
  assign nz = instr_word[OPC_MSB:OPC_LSB] == OPC_INC_SKIP_NZ;
  assign tk = ce && instr_valid && !squash && (z || nz);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  take_pulse_a: assert property (tk |=> executed) else $error("no exec");
  no_take_a: assert property (ce && !tk |=> !executed && !file_wr_en && !accum_wr_en) else $error("stray");
  acc_write_a: assert property (tk && !instr_word[DEST_BIT] |=> accum_wr_en && !file_wr_en
    && accum_wr_data == $past(file_rd_data) + 8'h01) else $error("acc");
  file_write_a: assert property (tk && instr_word[DEST_BIT] |=> file_wr_en && !accum_wr_en
    && file_wr_data == $past(file_rd_data) + 8'h01) else $error("file");
  zero_skip_a: assert property (tk && z && file_rd_data == 8'hff |=> squash) else $error("z skip");
  nz_skip_a: assert property (tk && nz && file_rd_data != 8'hff |=> squash) else $error("nz skip");
  no_skip_a: assert property (tk && (z == (file_rd_data != 8'hff)) |=> !squash) else $error("skip");
  status_quiet_a: assert property (status_wr_en == 1'b0) else $error("status");
  skip_end_a: assert property (ce && squash && instr_valid && !instr_two_word |=> !squash) else $error("len");
  freeze_hold_a: assert property (!ce |=> $stable(squash) && $stable(executed)) else $error("freeze");
  cover property (tk && z ##1 squash);
  cover property (!ce && squash);
  cover property (squash && instr_two_word ##1 squash);
  cover property (tk ##1 tk);
endmodule
bind isk_exec isk_monitor isk_monitor_i (.clk, .resetn, .ce, .instr_valid, .instr_two_word, .squash, .instr_word,
  .file_rd_data, .file_wr_data, .accum_wr_data, .file_wr_en, .accum_wr_en, .executed, .status_wr_en);

// file: test/increment_skip_instr_exec_tb.sv
/* Self-checking bench for isk_exec.
   Assumes the bench answers file reads in the same cycle. */
`timescale 1ns/1ps
module increment_skip_instr_exec_tb;
  import isk_pkg::*;
  logic clk = 0, resetn = 0, ce = 1, instr_valid = 0, instr_two_word = 0, ext_set_enable = 0;
  logic [15:0] instr_word = 0;
  logic [3:0] bank_select_register = 0;
  logic [11:0] frame_pointer = 0, file_rd_addr, file_wr_addr, p_a = 0;
  logic [7:0] file_rd_data = 0, file_wr_data, accum_wr_data, p_res = 0;
  logic file_wr_en, accum_wr_en, squash, executed, status_wr_en, p_tk = 0, p_d = 0;
  int bad_count = 0, checks = 0, st = 0, n;
  always #5 clk = ~clk;
  isk_exec isk_exec_i (.clk, .resetn, .ce, .instr_word, .instr_valid, .instr_two_word, .bank_select_register,
    .ext_set_enable, .frame_pointer, .file_rd_addr, .file_rd_data, .file_wr_en, .file_wr_addr, .file_wr_data,
    .accum_wr_en, .accum_wr_data, .squash, .executed, .status_wr_en);
  task chk(logic [11:0] got, logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  function logic [11:0] ea(logic [15:0] w);
    if (w[8]) return {bank_select_register, w[7:0]};
    if (ext_set_enable && w[7:0] <= INDEX_LIMIT) return frame_pointer + 12'(w[7:0]);
    return {(w[7:0] < ACCESS_SPLIT) ? 4'h0 : 4'hf, w[7:0]};
  endfunction
  task step(logic v, logic [15:0] w, logic t, logic [7:0] d, logic c = 1);
    logic tk;
    @(posedge clk);
    ce <= c;
    instr_valid <= v;
    instr_word <= w;
    instr_two_word <= t;
    file_rd_data <= d;
    bank_select_register <= 4'($urandom);
    ext_set_enable <= 1'($urandom);
    frame_pointer <= 12'($urandom);
    #1;
    chk(12'(executed), 12'(p_tk));
    chk(12'(file_wr_en), 12'(p_tk && p_d));
    chk(12'(accum_wr_en), 12'(p_tk && !p_d));
    if (p_tk && p_d) chk(file_wr_addr, p_a);
    if (p_tk && p_d) chk(12'(file_wr_data), 12'(p_res));
    if (p_tk && !p_d) chk(12'(accum_wr_data), 12'(p_res));
    chk(12'(status_wr_en), 12'h000);
    chk(12'(squash), 12'(st != 0));
    tk = v && st == 0 && (w[15:10] == OPC_INC_SKIP_Z || w[15:10] == OPC_INC_SKIP_NZ);
    if (tk) chk(file_rd_addr, ea(w));
    // Enable low at the coming edge: the design holds, so the model holds too
    if (!c) return;
    p_tk = tk;
    p_d = w[9];
    p_res = d + 8'h01;
    p_a = ea(w);
    if (v && st != 0) st = (st == 1 && t) ? 2 : 0;
    else if (tk && ((p_res == 8'h00) == (w[15:10] == OPC_INC_SKIP_Z))) st = 1;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    logic [15:0] w;
    n = $urandom(38);
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    // Skip, squashed own word flagged two-word, gap, second squash
    step(1, 16'h3e05, 0, 8'hff);
    step(1, 16'h4a10, 1, 8'h00);
    step(0, 16'h0000, 0, 8'h00);
    step(1, 16'h1234, 0, 8'h00);
    step(1, 16'h4805, 0, 8'h10);
    step(1, 16'h3e05, 0, 8'hff);
    step(1, 16'h3d7f, 0, 8'h05);
    step(1, 16'h4bff, 0, 8'hff);
    // Frozen while a skip is pending, then the squash goes on
    step(1, 16'h3e05, 0, 8'hff);
    step(1, 16'h1234, 0, 8'h00, 0);
    step(1, 16'h1234, 0, 8'h00);
    step(1, 16'h4805, 0, 8'h10, 0);
    step(1, 16'h4805, 0, 8'h10);
    repeat (600) begin
      n = $urandom_range(3);
      w = 16'($urandom);
      if (n == 0) w[15:10] = OPC_INC_SKIP_Z;
      if (n == 1) w[15:10] = OPC_INC_SKIP_NZ;
      step(1'($urandom_range(7) != 0), w, 1'($urandom), ($urandom_range(3) == 0) ? 8'hff : 8'($urandom),
           1'($urandom_range(7) != 0));
    end
    step(0, 16'h0000, 0, 8'h00);
    close_out();
  end
endmodule
